// ---- timer_pair_pkg.sv ----
// Constants shared by the timer pair configuration block and its lane unit.
// Assumes word-indexed register map, byte address is four times the index.
package timer_pair_pkg;

   // Bus geometry
   localparam int ADDR_W      = 12;
   localparam int DATA_W      = 32;
   localparam int INDEX_W     = ADDR_W - 2;
   localparam int REG_W       = 8;
   localparam int TIMER_COUNT = 2;

   // Register indexes (byte address = index * 4)
   localparam logic [INDEX_W-1:0] MODE_CFG_IDX = 10'h089;
   localparam logic [INDEX_W-1:0] RUN_CTL_IDX  = 10'h090;
   localparam logic [INDEX_W-1:0] CLOCK_CTL_IDX = 10'h091;
   localparam logic [INDEX_W-1:0] IRQ_CFG_IDX  = 10'h092;
   localparam logic [INDEX_W-1:0] STATUS_IDX   = 10'h093;

   // Reset values
   localparam logic [REG_W-1:0] MODE_CFG_RESET  = 8'h00;
   localparam logic [REG_W-1:0] RUN_CTL_RESET   = 8'h00;
   localparam logic [REG_W-1:0] CLOCK_CTL_RESET = 8'h00;
   localparam logic [REG_W-1:0] IRQ_CFG_RESET   = 8'h00;

   // Mode register field layout, per timer, stride between timers
   localparam int MODE_LSB     = 0;
   localparam int SOURCE_BIT   = 2;
   localparam int GATING_BIT   = 3;
   localparam int FIELD_STRIDE = 4;

   // Other field positions, timer index is added except to the split and hold bits
   localparam int CLOCK_PICK_LSB = 3;
   localparam int POLARITY_LSB   = 0;
   localparam int RUN_LSB        = 0;
   localparam int STAT_EN_LSB    = 0;
   localparam int STAT_SPLIT_BIT = 2;
   localparam int STAT_HOLD_BIT  = 3;

   // Counting modes
   typedef enum logic [1:0] {
      MODE_13BIT  = 2'h0,
      MODE_16BIT  = 2'h1,
      MODE_RELOAD = 2'h2,
      MODE_SPLIT  = 2'h3
   } mode_type;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : timer_pair_pkg

// ---- timer_lane_if.sv ----
// Carrier between the configuration block and one timer lane unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface timer_lane_if;
   logic run;
   logic gating;
   logic source;
   logic clock_pick;
   logic polarity;
   logic halt;
   logic gate_pin;
   logic count_pin;
   logic prescale_tick;
   logic enabled;
   logic advance;

   // Configuration side
   modport ctl (
      output run, gating, source, clock_pick, polarity, halt,
      output gate_pin, count_pin, prescale_tick,
      input  enabled, advance
   );

   // Lane unit side
   modport unit (
      input  run, gating, source, clock_pick, polarity, halt,
      input  gate_pin, count_pin, prescale_tick,
      output enabled, advance
   );
endinterface : timer_lane_if

// ---- timer_lane_unit.sv ----
// One timer lane: count enable and the advance strobe for the counter.
// Assumes pins are synchronous to aclk; config comes from the lane carrier.
`timescale 1ns/1ps
module timer_lane_unit (
   // Clock and reset
   input  wire logic   aclk,
   input  wire logic   aresetn,
   // Lane carrier
   timer_lane_if.unit  lane
);
   import timer_pair_pkg::*;

   logic prev_pin;
   logic enabled;
   logic advance;
   logic next_prev_pin;
   logic next_enabled;
   logic next_advance;
   logic pin_active;
   logic tick;

   // Enable and tick selection
   always_comb begin
      next_prev_pin = lane.count_pin;
      // Active level is programmable, not a fixed low
      pin_active    = (lane.gate_pin == lane.polarity);
      next_enabled  = lane.run & (~lane.gating | pin_active)
                      & ~lane.halt;
      if (lane.source) begin
         // Clock pick plays no part in counter function
         tick = prev_pin & ~lane.count_pin;
      end else begin
         tick = lane.clock_pick ? 1'b1 : lane.prescale_tick;
      end
      next_advance = next_enabled & tick;
   end

   // Registered lane state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_pin <= 1'b1;
         enabled  <= 1'b0;
         advance  <= 1'b0;
      end else begin
         prev_pin <= next_prev_pin;
         enabled  <= next_enabled;
         advance  <= next_advance;
      end
   end

   assign lane.enabled = enabled;
   assign lane.advance = advance;

endmodule : timer_lane_unit

// ---- timer_pair_mode_config.sv ----
// Mode configuration and count control for timer zero and timer one.
// Assumes an AXI4-Lite master on aclk and pins synchronous to aclk.
`timescale 1ns/1ps
module timer_pair_mode_config (
   // Clock and reset
   input  wire logic                               aclk,
   input  wire logic                               aresetn,
   // AXI4-Lite write address
   input  wire logic [timer_pair_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic [2:0]                         awprot,
   input  wire logic                               awvalid,
   output      logic                               awready,
   // AXI4-Lite write data
   input  wire logic [timer_pair_pkg::DATA_W-1:0]  wdata,
   input  wire logic [3:0]                         wstrb,
   input  wire logic                               wvalid,
   output      logic                               wready,
   // AXI4-Lite write response
   output      logic [1:0]                         bresp,
   output      logic                               bvalid,
   input  wire logic                               bready,
   // AXI4-Lite read address
   input  wire logic [timer_pair_pkg::ADDR_W-1:0]  araddr,
   input  wire logic [2:0]                         arprot,
   input  wire logic                               arvalid,
   output      logic                               arready,
   // AXI4-Lite read data
   output      logic [timer_pair_pkg::DATA_W-1:0]  rdata,
   output      logic [1:0]                         rresp,
   output      logic                               rvalid,
   input  wire logic                               rready,
   // Timer pins and internal clock strobe
   input  wire logic                               ext_irq_pin_zero,
   input  wire logic                               ext_irq_pin_one,
   input  wire logic                               count_input_zero,
   input  wire logic                               count_input_one,
   input  wire logic                               prescale_tick,
   // Timer control outputs
   output      logic                               timer_zero_advance,
   output      logic                               timer_one_advance,
   output      logic [1:0]                         timer_zero_mode,
   output      logic [1:0]                         timer_one_mode,
   output      logic                               timer_zero_split,
   output      logic                               timer_one_hold
);
   import timer_pair_pkg::*;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } wr_state_type;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } rd_state_type;

   // Register file
   logic [REG_W-1:0]     mode_cfg;
   logic [REG_W-1:0]     run_ctl;
   logic [REG_W-1:0]     clock_ctl;
   logic [REG_W-1:0]     irq_cfg;
   logic [REG_W-1:0]     next_mode_cfg;
   logic [REG_W-1:0]     next_run_ctl;
   logic [REG_W-1:0]     next_clock_ctl;
   logic [REG_W-1:0]     next_irq_cfg;
   logic [REG_W-1:0]     status;

   // Write channel state
   wr_state_type         wr_state;
   wr_state_type         next_wr_state;
   logic                 aw_held;
   logic                 w_held;
   logic [INDEX_W-1:0]   wr_index;
   logic [REG_W-1:0]     wr_byte;
   logic                 wr_lane0;
   logic                 next_aw_held;
   logic                 next_w_held;
   logic [INDEX_W-1:0]   next_wr_index;
   logic [REG_W-1:0]     next_wr_byte;
   logic                 next_wr_lane0;
   logic                 next_awready;
   logic                 next_wready;
   logic [1:0]           next_bresp;
   logic                 next_bvalid;

   // Read channel state
   rd_state_type         rd_state;
   rd_state_type         next_rd_state;
   logic [DATA_W-1:0]    next_rdata;
   logic [1:0]           next_rresp;
   logic                 next_rvalid;
   logic                 next_arready;

   // Derived outputs
   logic                 next_zero_split;
   logic                 next_one_hold;

   // Lane carriers and their per-timer inputs
   timer_lane_if         lane [TIMER_COUNT] ();
   logic [TIMER_COUNT-1:0] gate_pins;
   logic [TIMER_COUNT-1:0] count_pins;
   logic [TIMER_COUNT-1:0] lane_enabled;
   logic [TIMER_COUNT-1:0] lane_advance;

   assign gate_pins  = {ext_irq_pin_one, ext_irq_pin_zero};
   assign count_pins = {count_input_one, count_input_zero};

   // Per-timer field decode and lane instances
   for (genvar i = 0; i < TIMER_COUNT; i++) begin : g_lane
      localparam int BASE = i * FIELD_STRIDE;
      assign lane[i].run           = run_ctl[RUN_LSB + i];
      assign lane[i].gating        = mode_cfg[BASE + GATING_BIT];
      assign lane[i].source        = mode_cfg[BASE + SOURCE_BIT];
      assign lane[i].clock_pick    = clock_ctl[CLOCK_PICK_LSB + i];
      assign lane[i].polarity      = irq_cfg[POLARITY_LSB + i];
      // Only timer one stops in split mode; timer zero splits instead
      assign lane[i].halt          = (i == 1) &&
                                     (mode_cfg[BASE + MODE_LSB +: 2] == MODE_SPLIT);
      assign lane[i].gate_pin      = gate_pins[i];
      assign lane[i].count_pin     = count_pins[i];
      assign lane[i].prescale_tick = prescale_tick;
      assign lane_enabled[i]       = lane[i].enabled;
      assign lane_advance[i]       = lane[i].advance;

      timer_lane_unit u_lane (
         .aclk    (aclk),
         .aresetn (aresetn),
         .lane    (lane[i])
      );
   end

   assign timer_zero_advance = lane_advance[0];
   assign timer_one_advance  = lane_advance[1];
   // Mode fields go straight out of the config flops
   assign timer_zero_mode    = mode_cfg[MODE_LSB +: 2];
   assign timer_one_mode     = mode_cfg[FIELD_STRIDE + MODE_LSB +: 2];

   // Status view of the block's own state
   always_comb begin
      status                 = '0;
      status[STAT_EN_LSB +: TIMER_COUNT] = lane_enabled;
      status[STAT_SPLIT_BIT] = timer_zero_split;
      status[STAT_HOLD_BIT]  = timer_one_hold;
   end

   // Split and hold flags for the counter datapath
   always_comb begin
      next_zero_split = (mode_cfg[MODE_LSB +: 2] == MODE_SPLIT);
      next_one_hold   = (mode_cfg[FIELD_STRIDE + MODE_LSB +: 2] == MODE_SPLIT);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_zero_split <= 1'b0;
         timer_one_hold   <= 1'b0;
      end else begin
         timer_zero_split <= next_zero_split;
         timer_one_hold   <= next_one_hold;
      end
   end

   // Write path: address and data taken in either order
   always_comb begin
      next_wr_state  = wr_state;
      next_aw_held   = aw_held;
      next_w_held    = w_held;
      next_wr_index  = wr_index;
      next_wr_byte   = wr_byte;
      next_wr_lane0  = wr_lane0;
      next_bresp     = bresp;
      next_bvalid    = bvalid;
      next_mode_cfg  = mode_cfg;
      next_run_ctl   = run_ctl;
      next_clock_ctl = clock_ctl;
      next_irq_cfg   = irq_cfg;
      case (wr_state)
         WR_IDLE: begin
            if (awvalid && awready) begin
               next_aw_held  = 1'b1;
               next_wr_index = awaddr[ADDR_W-1:2];
            end
            if (wvalid && wready) begin
               next_w_held   = 1'b1;
               next_wr_byte  = wdata[REG_W-1:0];
               next_wr_lane0 = wstrb[0];
            end
            // Commit once both halves are in; status is read-only
            if (next_aw_held && next_w_held) begin
               next_aw_held  = 1'b0;
               next_w_held   = 1'b0;
               next_bvalid   = 1'b1;
               next_bresp    = RESP_OKAY;
               next_wr_state = WR_RESP;
               case (next_wr_index)
                  MODE_CFG_IDX: begin
                     if (next_wr_lane0) begin
                        next_mode_cfg = next_wr_byte;
                     end
                  end
                  RUN_CTL_IDX: begin
                     if (next_wr_lane0) begin
                        next_run_ctl = next_wr_byte;
                     end
                  end
                  CLOCK_CTL_IDX: begin
                     if (next_wr_lane0) begin
                        next_clock_ctl = next_wr_byte;
                     end
                  end
                  IRQ_CFG_IDX: begin
                     if (next_wr_lane0) begin
                        next_irq_cfg = next_wr_byte;
                     end
                  end
                  STATUS_IDX: begin
                     next_bresp = RESP_OKAY;
                  end
                  default: begin
                     next_bresp = RESP_SLVERR;
                  end
               endcase
            end
         end
         WR_RESP: begin
            if (bready) begin
               next_bvalid   = 1'b0;
               next_wr_state = WR_IDLE;
            end
         end
         default: begin
            next_wr_state = WR_IDLE;
            next_bvalid   = 1'b0;
         end
      endcase
      // Ready drops while a half is held, so one write at a time
      next_awready = (next_wr_state == WR_IDLE) && !next_aw_held;
      next_wready  = (next_wr_state == WR_IDLE) && !next_w_held;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state  <= WR_IDLE;
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         wr_index  <= '0;
         wr_byte   <= '0;
         wr_lane0  <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         bresp     <= RESP_OKAY;
         bvalid    <= 1'b0;
         mode_cfg  <= MODE_CFG_RESET;
         run_ctl   <= RUN_CTL_RESET;
         clock_ctl <= CLOCK_CTL_RESET;
         irq_cfg   <= IRQ_CFG_RESET;
      end else begin
         wr_state  <= next_wr_state;
         aw_held   <= next_aw_held;
         w_held    <= next_w_held;
         wr_index  <= next_wr_index;
         wr_byte   <= next_wr_byte;
         wr_lane0  <= next_wr_lane0;
         awready   <= next_awready;
         wready    <= next_wready;
         bresp     <= next_bresp;
         bvalid    <= next_bvalid;
         mode_cfg  <= next_mode_cfg;
         run_ctl   <= next_run_ctl;
         clock_ctl <= next_clock_ctl;
         irq_cfg   <= next_irq_cfg;
      end
   end

   // Read path: one read at a time, data captured at the address handshake
   always_comb begin
      next_rd_state = rd_state;
      next_rdata    = rdata;
      next_rresp    = rresp;
      next_rvalid   = rvalid;
      case (rd_state)
         RD_IDLE: begin
            if (arvalid && arready) begin
               next_rd_state = RD_DATA;
               next_rvalid   = 1'b1;
               next_rresp    = RESP_OKAY;
               next_rdata    = '0;
               case (araddr[ADDR_W-1:2])
                  MODE_CFG_IDX:  next_rdata[REG_W-1:0] = mode_cfg;
                  RUN_CTL_IDX:   next_rdata[REG_W-1:0] = run_ctl;
                  CLOCK_CTL_IDX: next_rdata[REG_W-1:0] = clock_ctl;
                  IRQ_CFG_IDX:   next_rdata[REG_W-1:0] = irq_cfg;
                  STATUS_IDX:    next_rdata[REG_W-1:0] = status;
                  default:       next_rresp = RESP_SLVERR;
               endcase
            end
         end
         RD_DATA: begin
            if (rready) begin
               next_rvalid   = 1'b0;
               next_rd_state = RD_IDLE;
            end
         end
         default: begin
            next_rd_state = RD_IDLE;
            next_rvalid   = 1'b0;
         end
      endcase
      next_arready = (next_rd_state == RD_IDLE);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= RD_IDLE;
         rdata    <= '0;
         rresp    <= RESP_OKAY;
         rvalid   <= 1'b0;
         arready  <= 1'b0;
      end else begin
         rd_state <= next_rd_state;
         rdata    <= next_rdata;
         rresp    <= next_rresp;
         rvalid   <= next_rvalid;
         arready  <= next_arready;
      end
   end

endmodule : timer_pair_mode_config

// ---- timer_pair_mode_config_asserts.sv ----
// Bus handshake and timer output checks for the timer pair configuration block.
// Assumes it is bound to the block and sees only the block's own ports.
`timescale 1ns/1ps
module timer_pair_mode_config_asserts (
   // Clock and reset
   input wire logic                              aclk,
   input wire logic                              aresetn,
   // Register bus
   input wire logic                              awvalid,
   input wire logic                              awready,
   input wire logic                              wvalid,
   input wire logic                              wready,
   input wire logic [1:0]                        bresp,
   input wire logic                              bvalid,
   input wire logic                              bready,
   input wire logic                              arvalid,
   input wire logic                              arready,
   input wire logic [timer_pair_pkg::DATA_W-1:0] rdata,
   input wire logic [1:0]                        rresp,
   input wire logic                              rvalid,
   input wire logic                              rready,
   // Timer outputs
   input wire logic                              timer_one_advance,
   input wire logic [1:0]                        timer_zero_mode,
   input wire logic [1:0]                        timer_one_mode,
   input wire logic                              timer_zero_split,
   input wire logic                              timer_one_hold
);
   import timer_pair_pkg::*;

   // One clock domain, so one default for all
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Handshake steps and the timer one split-mode window
   sequence wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence rd_taken;
      arvalid && arready;
   endsequence
   sequence one_stopped;
      (timer_one_mode == 2'h3) [*3];
   endsequence

   write_resp_a: assert property (wr_taken |=> bvalid && !awready && !wready)
      else $error("write response missing after address and data");
   read_resp_a: assert property (rd_taken |=> rvalid && !arready)
      else $error("read data missing after read address");
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped before taken");
   resp_done_a: assert property (bvalid && bready |=> !bvalid)
      else $error("write response repeated");
   rdata_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   zero_split_a: assert property ($stable(timer_zero_mode) |-> timer_zero_split == (timer_zero_mode == 2'h3))
      else $error("split flag disagrees with timer zero mode");
   one_hold_a: assert property ($stable(timer_one_mode) |-> timer_one_hold == (timer_one_mode == 2'h3))
      else $error("hold flag disagrees with timer one mode");
   one_stop_a: assert property (one_stopped |-> !timer_one_advance)
      else $error("timer one advanced while stopped");
endmodule : timer_pair_mode_config_asserts

bind timer_pair_mode_config timer_pair_mode_config_asserts u_chk (
   .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
   .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .timer_one_advance,
   .timer_zero_mode, .timer_one_mode, .timer_zero_split, .timer_one_hold);

// ---- timer_pair_mode_config_tb.sv ----
// Self-checking bench for the timer pair configuration block.
// Assumes the checker is bound separately; the bench acts as bus master and pin driver.
`timescale 1ns/1ps
module timer_pair_mode_config_tb;
   import timer_pair_pkg::*;
   typedef struct {logic [7:0] m, r, c, p; logic g0, g1; logic [7:0] e0, e1;} row_type;
   localparam logic [ADDR_W-1:0] A_MODE = {MODE_CFG_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] A_RUN  = {RUN_CTL_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] A_CLK  = {CLOCK_CTL_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] A_IRQ  = {IRQ_CFG_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] A_STAT = {STATUS_IDX, 2'b00};
   logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready, prescale_tick;
   logic              ext_irq_pin_zero, ext_irq_pin_one, count_input_zero, count_input_one;
   logic              timer_zero_advance, timer_one_advance, timer_zero_split, timer_one_hold;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, rv;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, rs, timer_zero_mode, timer_one_mode;
   int                n_fail, compares, cyc;
   logic [ADDR_W-1:0] adr [5] = '{A_MODE, A_RUN, A_CLK, A_IRQ, A_STAT};
   // Mode, run, clock, polarity, gate pins, then expected advances of each timer in 24 cycles
   row_type rows [13] = '{
      '{8'h00, 8'h03, 8'h00, 8'h00, 0, 0, 5, 5}, '{8'h11, 8'h01, 8'h00, 8'h00, 0, 0, 5, 0},
      '{8'h22, 8'h03, 8'h00, 8'h00, 0, 1, 5, 5}, '{8'h80, 8'h03, 8'h00, 8'h00, 0, 1, 5, 0},
      '{8'h80, 8'h03, 8'h00, 8'h00, 0, 0, 5, 5}, '{8'h80, 8'h03, 8'h00, 8'h02, 0, 1, 5, 5},
      '{8'h80, 8'h03, 8'h00, 8'h02, 0, 0, 5, 0}, '{8'h08, 8'h03, 8'h00, 8'h01, 0, 0, 0, 5},
      '{8'h08, 8'h03, 8'h00, 8'h01, 1, 0, 5, 5}, '{8'h44, 8'h03, 8'h18, 8'h00, 0, 0, 2, 2},
      '{8'h00, 8'h03, 8'h18, 8'h00, 0, 0, 24, 24}, '{8'hc4, 8'h03, 8'h08, 8'h00, 0, 1, 2, 0},
      '{8'h33, 8'h03, 8'h00, 8'h00, 0, 0, 5, 0}};

   timer_pair_mode_config u_dut (
      .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .ext_irq_pin_zero, .ext_irq_pin_one,
      .count_input_zero, .count_input_one, .prescale_tick, .timer_zero_advance,
      .timer_one_advance, .timer_zero_mode, .timer_one_mode, .timer_zero_split,
      .timer_one_hold);

   // Clock, 20 ns period
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic results();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results

   // Ceiling well above the several hundred cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end

   task automatic chk_data(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_data

   task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_resp

   // Ready is raised only after valid is seen, so the hold of each answer is exercised
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin
            awvalid <= 1'b0;
            ad = 1'b1;
         end
         if (!wd && wready === 1'b1) begin
            wvalid <= 1'b0;
            wd = 1'b1;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b1;
      @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b1;
      @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   // Ticks at 5 points, two count pin falls, then count advance pulses
   task automatic run_row(input row_type x);
      int k0;
      int k1;
      logic cp;
      k0 = 0;
      k1 = 0;
      ext_irq_pin_zero <= x.g0;
      ext_irq_pin_one <= x.g1;
      wr(A_MODE, {24'h0, x.m}, 4'h1, rs);
      wr(A_RUN, {24'h0, x.r}, 4'h1, rs);
      wr(A_CLK, {24'h0, x.c}, 4'h1, rs);
      wr(A_IRQ, {24'h0, x.p}, 4'h1, rs);
      repeat (4) @(posedge aclk);
      for (int i = 0; i < 24; i++) begin
         @(posedge aclk);
         cp = !((i >= 5 && i < 10) || (i >= 15 && i < 20));
         prescale_tick <= (i % 4 == 1) && (i < 20);
         count_input_zero <= cp;
         count_input_one <= cp;
         #2;
         k0 += (timer_zero_advance === 1'b1);
         k1 += (timer_one_advance === 1'b1);
      end
      chk_data("timer zero advances", x.e0, k0);
      chk_data("timer one advances", x.e1, k1);
      chk_data("mode outputs", {26'h0, x.m[1:0] == 2'h3, x.m[5:4] == 2'h3, x.m[5:4], x.m[1:0]},
               {26'h0, timer_zero_split, timer_one_hold, timer_one_mode, timer_zero_mode});
      rd(A_MODE, rv, rs);
      chk_data("mode readback", {24'h0, x.m}, rv);
   endtask : run_row

   // Main sequence
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'h0;
      prescale_tick = 1'b0;
      ext_irq_pin_zero = 1'b0;
      ext_irq_pin_one = 1'b0;
      count_input_zero = 1'b1;
      count_input_one = 1'b1;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (adr[i]) begin
         rd(adr[i], rv, rs);
         chk_data("reset value", 32'h0, rv);
         chk_resp("reset read resp", RESP_OKAY, rs);
      end
      rd(12'h000, rv, rs);
      chk_data("unmapped read", 32'h0, rv);
      chk_resp("unmapped read resp", RESP_SLVERR, rs);
      wr(12'h000, 32'h0000_00ff, 4'h1, rs);
      chk_resp("unmapped write resp", RESP_SLVERR, rs);
      wr(A_MODE, 32'habcd_ef5a, 4'hf, rs);
      rd(A_MODE, rv, rs);
      chk_data("upper bits dropped", 32'h0000_005a, rv);
      wr(A_MODE, 32'h0000_00ff, 4'h0, rs);
      chk_resp("no strobe resp", RESP_OKAY, rs);
      rd(A_MODE, rv, rs);
      chk_data("no strobe kept", 32'h0000_005a, rv);
      foreach (rows[i]) run_row(rows[i]);
      // Status is read only: split and hold set, timer one not enabled
      rd(A_STAT, rv, rs);
      chk_data("status", 32'h0000_000d, rv);
      wr(A_STAT, 32'h0000_00ff, 4'h1, rs);
      chk_resp("status write resp", RESP_OKAY, rs);
      rd(A_STAT, rv, rs);
      chk_data("status kept", 32'h0000_000d, rv);
      // Second reset in mid-run
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_MODE, rv, rs);
      chk_data("mode after reset", 32'h0, rv);
      results();
   end
endmodule : timer_pair_mode_config_tb
